// file: src/vits_irq_ctrl.sv
// Vectored interrupt controller with the main-clock time-base tick source.
`timescale 1ns/1ps

module vits_irq_ctrl #(
  parameter int TB_PERIOD_0 = vits_pkg::TB_PERIOD_0,
  parameter int TB_PERIOD_1 = vits_pkg::TB_PERIOD_1,
  parameter int TB_PERIOD_2 = vits_pkg::TB_PERIOD_2,
  parameter int TB_PERIOD_3 = vits_pkg::TB_PERIOD_3
) (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Register port.
  input  wire logic [7:0]                  regAddr,
  input  wire logic [7:0]                  regWrData,
  input  wire logic                        regWrStrobe,
  input  wire logic                        regRdStrobe,
  output logic      [7:0]                  regRdData,
  // Core events.
  input  wire logic                        instrEnd,
  input  wire logic                        trapExec,
  input  wire logic                        iretExec,
  input  wire logic                        haltExec,
  input  wire logic                        waitExec,
  input  wire logic                        maskSet,
  input  wire logic                        maskClr,
  input  wire vits_pkg::vits_cpu_regs_type cpuRegs,
  // Stack and vector answers to the core.
  output logic                             stackPushValid,
  output logic      [7:0]                  stackPushData,
  output logic                             stackPopReq,
  input  wire logic [7:0]                  stackPopData,
  output logic                             vectorValid,
  output logic      [15:0]                 vectorAddr,
  output logic                             restoreValid,
  output vits_pkg::vits_cpu_regs_type      restoreRegs,
  output logic                             globalMask,
  // External interrupt pins and their per-pin enables.
  input  wire logic [3:0]                  portAPins,
  input  wire logic [2:0]                  portFPins,
  input  wire logic [7:0]                  portBPins,
  input  wire logic [3:0]                  portAIrqEn,
  input  wire logic [2:0]                  portFIrqEn,
  input  wire logic [7:0]                  portBIrqEn,
  // Clock guard and peripheral sources.
  input  wire logic                        clockGuardDetect,
  input  wire logic [4:0]                  periphSet,
  input  wire logic [4:0]                  periphEnable,
  input  wire logic [4:0]                  periphWrZero,
  input  wire logic [4:0]                  periphStatusAccess,
  input  wire logic [4:0]                  periphAssocAccess,
  output logic      [4:0]                  periphPending,
  // Power state.
  output vits_pkg::vits_power_type         powerMode,
  output logic                             oscEnable,
  output logic                             periphClkEnable
);
  import vits_pkg::*;

  logic [7:0]          rdData_ff;
  logic [1:0]          tbSel_ff;
  logic                tbIe_ff;
  logic                tbFlag_ff;
  logic [TB_CNT_W-1:0] tbCount_ff;
  logic                cgIe_ff;
  logic [7:0]          extSense_ff;
  logic [NUM_EXT-1:0]  extPrev_ff;
  logic [NUM_EXT-1:0]  extEdge_ff;
  logic [NUM_EXT-1:0]  extLine;
  logic [NUM_EXT-1:0]  extAnyEn;
  logic [NUM_EXT-1:0]  extReq;
  logic [4:0]          periphLatch_ff;
  logic [4:0]          periphArmed_ff;
  logic [NUM_SRC-1:0]  srcReq;
  logic                anyReq;
  logic [3:0]          bestSrc;
  logic                iMask_ff;
  vits_state_type      state_ff;
  logic [2:0]          step_ff;
  logic                isTrap_ff;
  logic [3:0]          srcSel_ff;
  logic                resetVec_ff;
  logic                popDly_ff;
  vits_cpu_regs_type   saved_ff;
  vits_cpu_regs_type   popRegs_ff;
  logic                pushValid_ff;
  logic [7:0]          pushData_ff;
  logic                popReq_ff;
  logic                vecValid_ff;
  logic [15:0]         vecAddr_ff;
  logic                restValid_ff;
  vits_power_type      power_ff;
  logic                oscEn_ff;
  logic                perClkEn_ff;
  logic                tbEnd;
  logic                rdCsr;
  logic                wrCsr;
  logic                enterSvc;

  function automatic logic [TB_CNT_W-1:0] periodLast(input logic [1:0] sel);
    logic [TB_CNT_W-1:0] r;
    r = '0;
    case (sel)
      2'h0: r = TB_CNT_W'(TB_PERIOD_0 - 1);
      2'h1: r = TB_CNT_W'(TB_PERIOD_1 - 1);
      2'h2: r = TB_CNT_W'(TB_PERIOD_2 - 1);
      default: r = TB_CNT_W'(TB_PERIOD_3 - 1);
    endcase
    return r;
  endfunction

  assign rdCsr    = regRdStrobe && (regAddr == TB_CSR_ADDR);
  assign wrCsr    = regWrStrobe && (regAddr == TB_CSR_ADDR);
  assign tbEnd    = (tbCount_ff == '0) && (power_ff != PM_HALT);
  assign enterSvc = (state_ff == ST_VECT);

  // Register reads; a read of the control/status register also clears the tick flag.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else if (regRdStrobe) begin
      if (regAddr == TB_CSR_ADDR) begin
        rdData_ff <= {4'h0, tbSel_ff, tbIe_ff, tbFlag_ff};
      end else if (regAddr == CG_CTRL_ADDR) begin
        rdData_ff <= {5'h00, cgIe_ff, clockGuardDetect, 1'b0};
      end else if (regAddr == EXT_SENSE_ADDR) begin
        rdData_ff <= extSense_ff;
      end else begin
        rdData_ff <= 8'h00;
      end
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  // Control fields written by software.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbSel_ff    <= TB_CSR_RESET[TB_SEL_LSB+1:TB_SEL_LSB];
      tbIe_ff     <= TB_CSR_RESET[TB_IE_BIT];
      cgIe_ff     <= CG_CTRL_RESET[CG_IE_BIT];
      extSense_ff <= EXT_SENSE_RESET;
    end else if (regWrStrobe) begin
      if (regAddr == TB_CSR_ADDR) begin
        tbSel_ff <= regWrData[TB_SEL_LSB+1:TB_SEL_LSB];
        tbIe_ff  <= regWrData[TB_IE_BIT];
      end else if (regAddr == CG_CTRL_ADDR) begin
        cgIe_ff <= regWrData[CG_IE_BIT];
      end else if (regAddr == EXT_SENSE_ADDR) begin
        extSense_ff <= regWrData;
      end
    end
  end

  // Time-base counter; runs in every mode except full halt, where the oscillator stops.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbCount_ff <= TB_CNT_W'(TB_PERIOD_0 - 1);
    end else if (tbEnd) begin
      // The select is sampled only here, so a rewrite never cuts the running period short.
      tbCount_ff <= periodLast(tbSel_ff);
    end else if (power_ff != PM_HALT) begin
      tbCount_ff <= tbCount_ff - 1'b1;
    end
  end

  // Tick flag; the period end wins over a clearing read in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbFlag_ff <= TB_CSR_RESET[TB_FLAG_BIT];
    end else if (tbEnd) begin
      tbFlag_ff <= 1'b1;
    end else if (rdCsr) begin
      tbFlag_ff <= 1'b0;
    end
  end

  // External lines: enabled pins of a group are ANDed before detection.
  always_comb begin
    extLine[0]  = &(portAPins | ~portAIrqEn);
    extLine[1]  = &(portFPins | ~portFIrqEn);
    extLine[2]  = &(portBPins[3:0] | ~portBIrqEn[3:0]);
    extLine[3]  = &(portBPins[7:4] | ~portBIrqEn[7:4]);
    extAnyEn[0] = |portAIrqEn;
    extAnyEn[1] = |portFIrqEn;
    extAnyEn[2] = |portBIrqEn[3:0];
    extAnyEn[3] = |portBIrqEn[7:4];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      vits_sense_type sense;
      logic           rise;
      logic           fall;
      logic           edgeHit;
      assign sense   = vits_sense_type'(extSense_ff[2*gi+1:2*gi]);
      assign rise    = extLine[gi] && !extPrev_ff[gi];
      assign fall    = !extLine[gi] && extPrev_ff[gi];
      assign edgeHit = extAnyEn[gi] && (((sense == SENSE_RISE) && rise) ||
                       ((sense == SENSE_FALL) && fall) || ((sense == SENSE_BOTH) && (rise || fall)));
      assign extReq[gi] = (sense == SENSE_LOW) ? (extAnyEn[gi] && !extLine[gi]) : extEdge_ff[gi];

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          extPrev_ff[gi] <= 1'b1;
        end else begin
          extPrev_ff[gi] <= extLine[gi];
        end
      end

      // Edge latch; a new edge wins over the clear on handler entry.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          extEdge_ff[gi] <= 1'b0;
        end else if (edgeHit) begin
          extEdge_ff[gi] <= 1'b1;
        end else if (enterSvc && !isTrap_ff && (srcSel_ff == 4'(SRC_EXT0 + gi))) begin
          extEdge_ff[gi] <= 1'b0;
        end
      end
    end

    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
      // Request latch of one peripheral source; a set wins over any clear.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          periphLatch_ff[gi] <= 1'b0;
          periphArmed_ff[gi] <= 1'b0;
        end else if (periphSet[gi]) begin
          periphLatch_ff[gi] <= 1'b1;
        end else if (periphWrZero[gi]) begin
          periphLatch_ff[gi] <= 1'b0;
          periphArmed_ff[gi] <= 1'b0;
        end else if (periphArmed_ff[gi] && periphAssocAccess[gi]) begin
          periphLatch_ff[gi] <= 1'b0;
          periphArmed_ff[gi] <= 1'b0;
        end else if (periphStatusAccess[gi] && periphLatch_ff[gi]) begin
          periphArmed_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Request vector and fixed-priority choice of the lowest pending source.
  always_comb begin
    srcReq            = '0;
    srcReq[SRC_CLOCK] = (tbFlag_ff && tbIe_ff) || (clockGuardDetect && cgIe_ff);
    srcReq[SRC_EXT0 +: NUM_EXT] = extReq;
    srcReq[SRC_PERIPH0 +: NUM_PERIPH] = periphLatch_ff & periphEnable;
    anyReq  = |srcReq;
    bestSrc = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (srcReq[i]) begin
        bestSrc = 4'(i);
      end
    end
  end

  // Global mask bit.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iMask_ff <= 1'b1;
    end else if (enterSvc) begin
      iMask_ff <= 1'b1;
    end else if (state_ff == ST_RESTORE) begin
      iMask_ff <= 1'b0;
    end else if (instrEnd && (haltExec || waitExec) && (state_ff == ST_IDLE)) begin
      iMask_ff <= 1'b0;
    end else if (maskSet) begin
      iMask_ff <= 1'b1;
    end else if (maskClr) begin
      iMask_ff <= 1'b0;
    end
  end

  // Entry and return sequencer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      step_ff     <= 3'h0;
      isTrap_ff   <= 1'b0;
      srcSel_ff   <= 4'h0;
      resetVec_ff <= 1'b1;
      saved_ff    <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          step_ff <= 3'h0;
          if (resetVec_ff) begin
            resetVec_ff <= 1'b0;
          end else if (instrEnd && trapExec) begin
            state_ff  <= ST_PUSH;
            isTrap_ff <= 1'b1;
            saved_ff  <= cpuRegs;
          end else if (instrEnd && anyReq && !iMask_ff && (power_ff == PM_RUN)) begin
            state_ff  <= ST_PUSH;
            isTrap_ff <= 1'b0;
            srcSel_ff <= bestSrc;
            saved_ff  <= cpuRegs;
          end else if (instrEnd && iretExec) begin
            state_ff <= ST_POP;
          end
        end
        ST_PUSH: begin
          step_ff <= step_ff + 3'h1;
          if (step_ff == 3'(STACK_BYTES - 1)) begin
            state_ff <= ST_VECT;
          end
        end
        ST_VECT: begin
          state_ff <= ST_IDLE;
        end
        ST_POP: begin
          step_ff <= step_ff + 3'h1;
          if (step_ff == 3'(STACK_BYTES + 1)) begin
            state_ff <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Stack traffic: push PCL, PCH, X, A, CC; pops return CC, A, X, PCH, PCL.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pushValid_ff <= 1'b0;
      pushData_ff  <= 8'h00;
      popReq_ff    <= 1'b0;
      popDly_ff    <= 1'b0;
      popRegs_ff   <= '0;
    end else begin
      pushValid_ff <= (state_ff == ST_PUSH);
      case (step_ff)
        3'h0: pushData_ff <= saved_ff.pc[7:0];
        3'h1: pushData_ff <= saved_ff.pc[15:8];
        3'h2: pushData_ff <= saved_ff.x;
        3'h3: pushData_ff <= saved_ff.a;
        default: pushData_ff <= saved_ff.cc;
      endcase
      popReq_ff <= (state_ff == ST_POP) && (step_ff < 3'(STACK_BYTES));
      popDly_ff <= popReq_ff;
      if (popDly_ff) begin
        case (step_ff)
          3'h2: popRegs_ff.cc <= stackPopData & ~(8'h01 << CC_MASK_BIT);
          3'h3: popRegs_ff.a <= stackPopData;
          3'h4: popRegs_ff.x <= stackPopData;
          3'h5: popRegs_ff.pc[15:8] <= stackPopData;
          default: popRegs_ff.pc[7:0] <= stackPopData;
        endcase
      end
    end
  end

  // Vector and restore answers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vecValid_ff  <= 1'b0;
      vecAddr_ff   <= 16'h0000;
      restValid_ff <= 1'b0;
    end else begin
      vecValid_ff  <= enterSvc || ((state_ff == ST_IDLE) && resetVec_ff);
      restValid_ff <= (state_ff == ST_RESTORE);
      if ((state_ff == ST_IDLE) && resetVec_ff) begin
        vecAddr_ff <= VEC_RESET;
      end else if (enterSvc && isTrap_ff) begin
        vecAddr_ff <= VEC_TRAP;
      end else if (enterSvc) begin
        vecAddr_ff <= VEC_SRC0 - {11'h000, srcSel_ff, 1'b0};
      end
    end
  end

  // Power modes and wake-up.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ff    <= PM_RUN;
      oscEn_ff    <= 1'b1;
      perClkEn_ff <= 1'b1;
    end else begin
      case (power_ff)
        PM_RUN: begin
          if (instrEnd && haltExec && (state_ff == ST_IDLE) && !resetVec_ff) begin
            power_ff    <= tbIe_ff ? PM_ACTIVE_HALT : PM_HALT;
            oscEn_ff    <= tbIe_ff;
            perClkEn_ff <= 1'b0;
          end else if (instrEnd && waitExec && (state_ff == ST_IDLE) && !resetVec_ff) begin
            power_ff <= PM_WAIT;
          end
        end
        PM_WAIT: begin
          if (anyReq) begin
            power_ff <= PM_RUN;
          end
        end
        default: begin
          if (srcReq[SRC_CLOCK] || (|extReq)) begin
            power_ff    <= PM_RUN;
            oscEn_ff    <= 1'b1;
            perClkEn_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  assign regRdData       = rdData_ff;
  assign stackPushValid  = pushValid_ff;
  assign stackPushData   = pushData_ff;
  assign stackPopReq     = popReq_ff;
  assign vectorValid     = vecValid_ff;
  assign vectorAddr      = vecAddr_ff;
  assign restoreValid    = restValid_ff;
  assign restoreRegs     = popRegs_ff;
  assign globalMask      = iMask_ff;
  assign periphPending   = periphLatch_ff;
  assign powerMode       = power_ff;
  assign oscEnable       = oscEn_ff;
  assign periphClkEnable = perClkEn_ff;

endmodule // vits_irq_ctrl

// file: src/vits_pkg.sv
// Package for the vectored interrupt logic and its time-base tick source.
package vits_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] TB_CSR_ADDR     = 8'h29;
  localparam logic [7:0] CG_CTRL_ADDR    = 8'h2C;
  localparam logic [7:0] EXT_SENSE_ADDR  = 8'h2D;

  // Field positions.
  localparam int TB_SEL_LSB  = 2;
  localparam int TB_IE_BIT   = 1;
  localparam int TB_FLAG_BIT = 0;
  localparam int CG_IE_BIT   = 2;
  localparam int CG_DET_BIT  = 1;
  localparam int CC_MASK_BIT = 3;

  // Reset values.
  localparam logic [7:0] TB_CSR_RESET    = 8'h01;
  localparam logic [7:0] CG_CTRL_RESET   = 8'h00;
  localparam logic [7:0] EXT_SENSE_RESET = 8'h00;

  // Oscillator cycles per tick for each period select value.
  localparam int TB_PERIOD_0 = 32000;
  localparam int TB_PERIOD_1 = 64000;
  localparam int TB_PERIOD_2 = 160000;
  localparam int TB_PERIOD_3 = 400000;
  localparam int TB_CNT_W    = 19;

  // Source numbering and vectors.
  localparam int NUM_SRC     = 14;
  localparam int NUM_EXT     = 4;
  localparam int NUM_PERIPH  = 5;
  localparam int SRC_CLOCK   = 1;
  localparam int SRC_EXT0    = 2;
  localparam int SRC_PERIPH0 = 7;
  localparam int STACK_BYTES = 5;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0  = 16'hFFFA;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_BOTH = 2'h3
  } vits_sense_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PUSH    = 3'h1,
    ST_VECT    = 3'h3,
    ST_POP     = 3'h2,
    ST_RESTORE = 3'h6
  } vits_state_type;

  typedef enum logic [1:0] {
    PM_RUN         = 2'h0,
    PM_WAIT        = 2'h1,
    PM_ACTIVE_HALT = 2'h3,
    PM_HALT        = 2'h2
  } vits_power_type;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  cc;
  } vits_cpu_regs_type;

endpackage

// file: test/tb_top.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  import vits_pkg::*;
  logic              ref_clk = 0, rst_n = 0, regWrStrobe = 0, regRdStrobe = 0, instrEnd = 0;
  logic              trapExec = 0, iretExec = 0, haltExec = 0, waitExec = 0, maskSet = 0;
  logic              maskClr = 0, clockGuardDetect = 0, rdPend = 0, globalMask, oscEnable;
  logic              stackPushValid, stackPopReq, vectorValid, restoreValid, periphClkEnable;
  logic [2:0]        portFPins = 3'h7, portFIrqEn;
  logic [3:0]        portAPins = 4'h0, portAIrqEn = 4'h0;
  logic [4:0]        periphSet = '0, periphEnable = '0, periphWrZero = '0, periphPending;
  logic [4:0]        periphStatusAccess = '0, periphAssocAccess = '0;
  logic [7:0]        regAddr = '0, regWrData = '0, regRdData, stackPushData, stackPopData;
  logic [7:0]        portBPins = 8'hFF, portBIrqEn, e8, m8, rdQ[$], mkQ[$];
  logic [15:0]       vectorAddr, e16, vecQ[$];
  int                failures = 0, comparisons = 0, t;
  int                per[4] = '{20, 40, 100, 250};
  vits_cpu_regs_type cpuRegs = '0, restoreRegs, r, er, resQ[$];
  vits_power_type    powerMode;

  vits_irq_ctrl #(.TB_PERIOD_0(20), .TB_PERIOD_1(40), .TB_PERIOD_2(100), .TB_PERIOD_3(250))
    vits_irq_ctrl_inst (.*);
  vits_core_model vits_core_model_inst (.ref_clk, .rst_n, .stackPushValid, .stackPushData,
    .stackPopReq, .stackPopData);

  always #50 ref_clk = ~ref_clk;

  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, e, m);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    rdQ.push_back(e);
    mkQ.push_back(m);
    tick();
    regRdStrobe <= 1'b0;
    tick();
  endtask
  task automatic wr(logic [7:0] a, d);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    tick();
    regWrStrobe <= 1'b0;
    tick();
  endtask
  // Reads every cycle until the flag shows; t starts at the cycles spent away from reading.
  task automatic poll(int gap, output int n);
    n = gap;
    regRdStrobe <= 1'b1;
    regAddr <= TB_CSR_ADDR;
    do begin
      rdQ.push_back(8'h00);
      mkQ.push_back(8'hF0);
      tick();
      n++;
    end while (regRdData[TB_FLAG_BIT] !== 1'b1 && n < 400);
    regRdStrobe <= 1'b0;
    tick();
  endtask
  task automatic ev(logic [2:0] k);
    {trapExec, iretExec, haltExec} <= k;
    instrEnd <= 1'b1;
    tick();
    {trapExec, iretExec, haltExec} <= 3'b000;
    instrEnd <= 1'b0;
    tick(12);
  endtask
  task automatic pul(logic [1:0] m, logic [4:0] s = '0, w = '0, st = '0, as = '0);
    {maskSet, maskClr} <= m;
    periphSet <= s;
    periphWrZero <= w;
    periphStatusAccess <= st;
    periphAssocAccess <= as;
    tick();
    {maskSet, maskClr} <= 2'b00;
    {periphSet, periphWrZero, periphStatusAccess, periphAssocAccess} <= '0;
    tick();
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (rdPend) begin
      e8 = rdQ.pop_front();
      m8 = mkQ.pop_front();
      `CHK("regRdData", e8, regRdData & m8)
    end
    if (vectorValid) begin
      e16 = vecQ.pop_front();
      `CHK("vectorAddr", e16, vectorAddr)
    end
    if (restoreValid) begin
      er = resQ.pop_front();
      `CHK("restoreRegs", er, restoreRegs)
    end
    rdPend <= regRdStrobe;
  end

  // The whole run needs under three thousand cycles.
  initial begin
    #(10000 * 100);
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(76378));
    portFIrqEn = 3'($urandom);
    portBIrqEn = 8'($urandom);
    vecQ.push_back(VEC_RESET);
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    rd(TB_CSR_ADDR, 8'h01, 8'hFF);
    rd(TB_CSR_ADDR, 8'h00, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    wr(TB_CSR_ADDR, 8'($urandom) & 8'hF0);
    rd(TB_CSR_ADDR, 8'h00, 8'hFE);
    $display("test registers done");
    repeat (2) poll(1, t);
    for (int i = 1; i < 4; i++) begin
      wr(TB_CSR_ADDR, 8'(i << TB_SEL_LSB));
      poll(3, t);
      `CHK("old period", per[i - 1], t)
      poll(1, t);
      `CHK("new period", per[i], t)
    end
    $display("test periods done");
    r = {$urandom, 8'($urandom)};
    cpuRegs <= r;
    vecQ.push_back(VEC_TRAP);
    ev(3'b100);
    r.cc[CC_MASK_BIT] = 1'b0;
    resQ.push_back(r);
    ev(3'b010);
    `CHK("globalMask", 1'b0, globalMask)
    periphEnable <= 5'h1F;
    pul(2'b10, 5'h12);
    ev(3'b000);
    `CHK("periphPending", 5'h12, periphPending)
    vecQ.push_back(16'hFFEA);
    pul(2'b01);
    ev(3'b000);
    pul(2'b00, 5'h00, 5'h02, 5'h10);
    pul(2'b00, 5'h00, 5'h00, 5'h00, 5'h10);
    `CHK("periphPending", 5'h00, periphPending)
    wr(EXT_SENSE_ADDR, 8'h01);
    portAPins <= 4'h7;
    portAIrqEn <= 4'hF;
    pul(2'b01);
    ev(3'b000);
    portAPins <= 4'hF;
    vecQ.push_back(16'hFFF6);
    tick(2);
    ev(3'b000);
    pul(2'b01);
    ev(3'b000);
    waitExec <= 1'b1;
    ev(3'b000);
    waitExec <= 1'b0;
    `CHK("powerMode", PM_WAIT, powerMode)
    vecQ.push_back(16'hFFE8);
    pul(2'b00, 5'h04);
    tick();
    `CHK("powerMode", PM_RUN, powerMode)
    r = {$urandom, 8'($urandom)};
    cpuRegs <= r;
    ev(3'b000);
    pul(2'b00, 5'h00, 5'h04);
    r.cc[CC_MASK_BIT] = 1'b0;
    resQ.push_back(r);
    ev(3'b010);
    wr(CG_CTRL_ADDR, 8'h04);
    clockGuardDetect <= 1'b1;
    portBIrqEn <= 8'hF0;
    portBPins <= 8'h7F;
    rd(CG_CTRL_ADDR, 8'h06, 8'hFF);
    vecQ.push_back(16'hFFF8);
    vecQ.push_back(16'hFFF0);
    ev(3'b000);
    clockGuardDetect <= 1'b0;
    pul(2'b01);
    ev(3'b000);
    portBPins <= 8'hFF;
    pul(2'b10);
    wr(TB_CSR_ADDR, 8'h0E);
    rd(TB_CSR_ADDR, 8'h0E, 8'hFE);
    ev(3'b001);
    `CHK("powerMode", PM_ACTIVE_HALT, powerMode)
    t = 0;
    while (powerMode !== PM_RUN && t < 300) begin
      tick();
      t++;
    end
    `CHK("powerMode", PM_RUN, powerMode)
    vecQ.push_back(16'hFFF8);
    ev(3'b000);
    wr(TB_CSR_ADDR, 8'h0C);
    ev(3'b001);
    `CHK("powerMode", PM_HALT, powerMode)
    $display("test interrupts done");
    conclude();
  end
endmodule // tb_top

// file: test/vits_core_model.sv
// Core-side model of the stack memory used on entry and return.
`timescale 1ns/1ps
module vits_core_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Stack traffic.
  input  wire logic       stackPushValid,
  input  wire logic [7:0] stackPushData,
  input  wire logic       stackPopReq,
  output logic      [7:0] stackPopData
);
  logic [7:0] stack[$];

  // Bytes return last in first out; between pops the bus toggles so nothing stale is seen.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack.delete();
      stackPopData <= 8'h00;
    end else begin
      if (stackPushValid) stack.push_back(stackPushData);
      if (stackPopReq && stack.size() > 0) stackPopData <= stack.pop_back();
      else stackPopData <= ~stackPopData;
    end
  end
endmodule // vits_core_model

// file: test/vits_irq_ctrl_properties.sv
// Port-level properties of the vectored interrupt controller.
`timescale 1ns/1ps
module vits_irq_ctrl_properties (
  // Clock and reset.
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  // Register port.
  input wire logic [7:0]                  regAddr,
  input wire logic                        regRdStrobe,
  input wire logic [7:0]                  regRdData,
  // Core events and answers.
  input wire logic                        instrEnd,
  input wire logic                        trapExec,
  input wire logic                        iretExec,
  input wire logic                        stackPushValid,
  input wire logic                        stackPopReq,
  input wire logic                        vectorValid,
  input wire logic [15:0]                 vectorAddr,
  input wire logic                        restoreValid,
  input wire vits_pkg::vits_cpu_regs_type restoreRegs,
  input wire logic                        globalMask,
  // Peripheral latches and power state.
  input wire logic [4:0]                  periphSet,
  input wire logic [4:0]                  periphWrZero,
  input wire logic [4:0]                  periphPending,
  input wire vits_pkg::vits_power_type    powerMode,
  input wire logic                        oscEnable,
  input wire logic                        periphClkEnable
);
  import vits_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_RESERVED: assert property (regRdStrobe && regAddr == TB_CSR_ADDR |=>
    regRdData[7:4] == 4'h0) else $error("reserved bits read nonzero");
  AST_PUSH_SEQ: assert property ($rose(stackPushValid) |-> stackPushValid [*5] ##1
    (vectorValid && !stackPushValid)) else $error("push burst not five bytes then vector");
  AST_MASK_ON_VECTOR: assert property (vectorValid |-> globalMask)
    else $error("mask clear at vector load");
  AST_TRAP_VECTOR: assert property (instrEnd && trapExec |-> ##7
    (vectorValid && vectorAddr == VEC_TRAP)) else $error("trap vector missing");
  AST_RETURN: assert property (instrEnd && iretExec && !trapExec |-> ##2 stackPopReq [*5]
    ##3 (restoreValid && !globalMask && !restoreRegs.cc[CC_MASK_BIT]))
    else $error("return sequence wrong");
  AST_VECTOR_MAP: assert property (vectorValid |-> vectorAddr inside {16'hFFFE,
    16'hFFFC, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEC, 16'hFFEA,
    16'hFFE8, 16'hFFE6, 16'hFFE4}) else $error("vector outside the map");
  AST_HALT_CLOCKS: assert property (powerMode inside {PM_HALT, PM_ACTIVE_HALT} |->
    !periphClkEnable && (oscEnable == (powerMode == PM_ACTIVE_HALT)))
    else $error("clock enables wrong in halt");
  AST_PEND_CLEAR: assert property ((periphWrZero & ~periphSet) != 5'h00 |=>
    (periphPending & $past(periphWrZero & ~periphSet)) == 5'h00)
    else $error("pending latch survived write of zero");
endmodule // vits_irq_ctrl_properties

bind vits_irq_ctrl vits_irq_ctrl_properties vits_irq_ctrl_properties_inst (.*);
